// ===== hw/clkgen_pkg.sv
// Purpose: Shared constants for the clock generator controller
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes: Field positions, reset values and mode codes are named here once
package clkgen_pkg;

    // ============================================================
    // Register byte addresses
    localparam logic [31:0] ADDR_PLL_CONTROL_STATUS = 32'h01B7C100;
    localparam logic [31:0] ADDR_PLL_MULTIPLIER = 32'h01B7C110;
    localparam logic [31:0] ADDR_PRESCALE_DIVIDER = 32'h01B7C114;
    localparam logic [31:0] ADDR_CORE_CLOCK_DIVIDER = 32'h01B7C118;
    localparam logic [31:0] ADDR_BUS_CLOCK_DIVIDER = 32'h01B7C11C;
    localparam logic [31:0] ADDR_MEMORY_CLOCK_DIVIDER = 32'h01B7C120;
    localparam logic [31:0] ADDR_OSCILLATOR_OUTPUT_DIVIDER = 32'h01B7C124;

    // ============================================================
    // Control and status field positions
    localparam int STABLE_POS = 6;
    localparam int PLL_RESET_POS = 3;
    localparam int MUST_ZERO_POS = 2;
    localparam int PLL_POWERDOWN_POS = 1;
    localparam int PLL_PATH_POS = 0;

    // Divider and multiplier field layout
    localparam int RATIO_W = 5;
    localparam int DIV_ENABLE_POS = 15;

    // ============================================================
    // Reset values
    localparam logic RST_PLL_RESET = 1'b1;
    localparam logic RST_PLL_POWERDOWN = 1'b0;
    localparam logic RST_PLL_PATH = 1'b0;
    localparam logic [4:0] RST_MULTIPLY = 5'h07;
    localparam logic RST_DIV_ENABLE = 1'b1;
    localparam logic [4:0] RST_PRESCALE_RATIO = 5'h00;
    localparam logic [4:0] RST_CORE_RATIO = 5'h00;
    localparam logic [4:0] RST_BUS_RATIO = 5'h01;
    localparam logic [4:0] RST_MEMORY_RATIO = 5'h01;
    localparam logic [4:0] RST_OSC_RATIO = 5'h07;

    // ============================================================
    // Power-down select codes that stop the PLL clock
    localparam logic [5:0] CLOCK_STOP_MODE = 6'h1A;
    localparam logic [5:0] DEEP_SLEEP_MODE = 6'h1C;

    // Reference clock edges counted before the input is deemed stable
    localparam int STABLE_EDGES_DEFAULT = 4096;

endpackage

// ===== hw/clkgen_ctrl.sv
// Purpose: Programmable clock generator controller with APB registers
// Assumes: Reference and PLL clocks are far slower than pclk and are sampled
// Notes: All generated clocks are registered levels rebuilt on pclk
//
// Summary of operation
// R1: Stable bit reads 1 after input count
// R2: PLL reset bit holds PLL reset, default 1
// R3: Software writes zero to bit two
// R4: Power-down bit stops PLL when set
// R5: Mode zero bypasses prescale and PLL
// R6: Mode one clocks system from PLL output
// R7: Reserved fields read zero, writes ignored
// R8: Multiplier field five bits, default times seven
// R9: Software avoids unsupported multiplier codes
// R10: Divider enable bit fifteen stops its output
// R11: Ratio code n divides by n plus one
// R12: Divider ratio reset values one,one,two,two
// R13: Software keeps core and bus dividers enabled
// R14: Software sets bus ratio twice core ratio
// R15: Oscillator divider enable stops raw clock
// R16: Oscillator ratio defaults to divide by eight
// R17: Raw clock comes from reference, not PLL
// R18: Deep sleep stops clocks only on PLL path
// R19: Software selects PLL before deep sleep
// R20: Software prefers power-down bit for sleep
// R21: Software writes whole power-down field at once
// R22: Power-down gates only reference and raw clock; the code gates the PLL clock edges too
// R23: Software holds PLL reset 125 ns minimum
// R24: Software waits lock time before PLL mode
// R25: Software bypasses while changing PLL input
// R26: Software orders core and bus ratio writes
// R27: Source and ratio changes make no runt pulses
// R28: Multiplier and ratios change at safe boundaries
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps

// ============================================================
// One divider: counts source edges, updates settings at period end
module clk_divider #(
    parameter logic [4:0] RST_RATIO = 5'h00,
    parameter logic RST_EN = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Source edge strobe, either polarity
    input wire logic src_edge,
    // Programmed settings
    input wire logic [4:0] ratio,
    input wire logic enable,
    // Divided clock level
    output logic clk_out
);
    logic [4:0] cnt; // Edges since last toggle
    logic [4:0] act_ratio; // Ratio in force
    logic act_en; // Enable in force
    wire last_edge = src_edge && (cnt == act_ratio);
    // Period end: output high or held off, safe to take new settings
    wire boundary = last_edge && (clk_out || !act_en);

    // Toggle every ratio+1 source edges, so the period is ratio+1 sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 5'h00;
            act_ratio <= RST_RATIO;
            act_en <= RST_EN;
            clk_out <= 1'b0;
        end else if (boundary) begin
            // Close the period low and load settings [R28][R27]
            cnt <= 5'h00;
            clk_out <= 1'b0;
            act_ratio <= ratio;
            act_en <= enable;
        end else if (last_edge) begin
            cnt <= 5'h00;
            clk_out <= act_en & ~clk_out; // [R11][R10]
        end else if (src_edge) begin
            cnt <= cnt + 5'h01;
        end
    end

    chk_div_off: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        !act_en |=> !clk_out) else $error("disabled divider drives a clock");
    chk_div_toggle: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        last_edge && act_en && !clk_out |=> clk_out) else $error("divider missed toggle");
endmodule

// ============================================================
// Top: register file, source selection and the divider chain
module clkgen_ctrl
    import clkgen_pkg::*;
#(
    parameter int STABLE_EDGES = STABLE_EDGES_DEFAULT
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources from pins and the PLL macro
    input wire logic reference_clock_input,
    input wire logic pll_output_clock,
    // CPU power-down request, pclk domain
    input wire logic [5:0] powerdown_select_field,
    // PLL macro controls
    output logic pll_reset,
    output logic pll_powerdown,
    output logic [4:0] pll_multiplier,
    output logic pll_reference_clock,
    // Generated clocks
    output logic core_clock,
    output logic peripheral_bus_clock,
    output logic memory_interface_clock,
    output logic raw_clock_output
);
    // ============================================================
    // Input synchronisers and edge strobes
    logic [2:0] ref_sync; // [0] metastable stage, read only by [1]
    logic [2:0] pll_sync; // Same arrangement for the PLL clock

    // Two flops, then a third for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync <= 3'h0;
            pll_sync <= 3'h0;
        end else begin
            ref_sync <= {ref_sync[1:0], reference_clock_input};
            pll_sync <= {pll_sync[1:0], pll_output_clock};
        end
    end

    wire ref_edge = ref_sync[2] ^ ref_sync[1];
    wire pll_edge = pll_sync[2] ^ pll_sync[1];
    wire ref_rise = ref_sync[1] & ~ref_sync[2];

    // ============================================================
    // Register storage
    logic ctl_rst; // PLL reset bit
    logic ctl_pwrdn; // PLL power-down bit
    logic ctl_path; // PLL path select bit
    logic [4:0] mult; // Multiply mode field
    logic [4:0] ratio [5]; // Prescale, core, bus, memory, oscillator
    logic [4:0] div_en; // Matching enable bits
    logic stable_bit; // Reference deemed stable
    logic [12:0] stable_cnt; // Reference rising edges counted until stable

    // Address decode
    wire hit_csr = (paddr == ADDR_PLL_CONTROL_STATUS);
    wire hit_mul = (paddr == ADDR_PLL_MULTIPLIER);
    wire [4:0] hit_div;
    assign hit_div[0] = (paddr == ADDR_PRESCALE_DIVIDER);
    assign hit_div[1] = (paddr == ADDR_CORE_CLOCK_DIVIDER);
    assign hit_div[2] = (paddr == ADDR_BUS_CLOCK_DIVIDER);
    assign hit_div[3] = (paddr == ADDR_MEMORY_CLOCK_DIVIDER);
    assign hit_div[4] = (paddr == ADDR_OSCILLATOR_OUTPUT_DIVIDER);
    wire mapped = hit_csr | hit_mul | (|hit_div);

    // Transfer completes on the edge where pready is seen high
    wire access = psel & penable;
    wire wr_done = access & pready & pwrite & mapped;

    // Read mux, reserved bits read zero [R7]
    wire [31:0] csr_rd = {25'h0, stable_bit, 2'b00, ctl_rst, 1'b0, ctl_pwrdn, ctl_path};
    logic [31:0] div_rd;
    always_comb begin
        div_rd = 32'h0;
        for (int i = 0; i < 5; i++) begin
            if (hit_div[i]) begin
                div_rd = {16'h0, div_en[i], 10'h000, ratio[i]};
            end
        end
    end
    wire [31:0] next_prdata = hit_csr ? csr_rd : (hit_mul ? {27'h0, mult} : div_rd);

    // APB answer: one wait state, then ready with data or error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= (pwrite || !mapped) ? 32'h0 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control bits; only documented fields take write data [R7]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_rst <= RST_PLL_RESET; // [R2]
            ctl_pwrdn <= RST_PLL_POWERDOWN; // [R4]
            ctl_path <= RST_PLL_PATH; // [R5]
            mult <= RST_MULTIPLY; // [R8]
        end else if (wr_done && hit_csr) begin
            // Bit two is not stored, software keeps it zero [R3]
            ctl_rst <= pwdata[PLL_RESET_POS]; // [R2]
            ctl_pwrdn <= pwdata[PLL_POWERDOWN_POS]; // [R4]
            ctl_path <= pwdata[PLL_PATH_POS]; // [R5][R6]
        end else if (wr_done && hit_mul) begin
            mult <= pwdata[RATIO_W-1:0]; // [R8]
        end
    end

    // Divider settings with their reset values [R12][R16]
    localparam logic [4:0] RST_RATIOS [5] = '{RST_PRESCALE_RATIO, RST_CORE_RATIO,
        RST_BUS_RATIO, RST_MEMORY_RATIO, RST_OSC_RATIO};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                ratio[i] <= RST_RATIOS[i]; // [R12][R16]
                div_en[i] <= RST_DIV_ENABLE; // [R10][R15]
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (wr_done && hit_div[i]) begin
                    ratio[i] <= pwdata[RATIO_W-1:0]; // [R11]
                    div_en[i] <= pwdata[DIV_ENABLE_POS]; // [R10][R15]
                end
            end
        end
    end

    // ============================================================
    // Input stability counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_cnt <= 13'h0000;
            stable_bit <= 1'b0;
        end else if (!stable_bit && ref_rise) begin
            // Still counting: stable bit stays low until the last edge [R1]
            stable_cnt <= stable_cnt + 13'h0001;
            stable_bit <= (stable_cnt == 13'(STABLE_EDGES - 1)); // [R1]
        end
    end

    // ============================================================
    // Source selection and deep power-down gating
    logic act_path; // Path select in force
    logic clk_stop; // Deep sleep stops clocks
    wire deep_req = (powerdown_select_field == CLOCK_STOP_MODE)
        || (powerdown_select_field == DEEP_SLEEP_MODE);
    // Both sources and the core clock low: switching now cannot cut a pulse short
    // Bus and memory clocks may run in opposite phases, so waiting on them could stall forever
    wire quiet = !ref_sync[1] && !pll_sync[1] && !core_clock;

    // Apply the path select only at a quiet point [R27]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_path <= RST_PLL_PATH;
            clk_stop <= 1'b0;
        end else begin
            if (quiet) begin
                act_path <= ctl_path; // [R5][R6][R27]
            end
            // Stop has effect only while the PLL path is in use [R18]
            clk_stop <= deep_req & act_path; // [R18][R19]
        end
    end

    // Both the reference input and the PLL clock edges are gated here [R22]
    wire ref_edge_g = ref_edge & ~clk_stop; // [R22]
    wire pll_edge_g = pll_edge & ~clk_stop; // [R18]
    wire sys_edge = act_path ? pll_edge_g : ref_edge_g; // [R5][R6]

    // PLL macro controls; multiplier follows only while bypassed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_reset <= RST_PLL_RESET;
            pll_powerdown <= RST_PLL_POWERDOWN;
            pll_multiplier <= RST_MULTIPLY;
        end else begin
            pll_reset <= ctl_rst; // [R2]
            pll_powerdown <= ctl_pwrdn; // [R4]
            if (!act_path) begin
                pll_multiplier <= mult; // [R8][R28]
            end
        end
    end

    // ============================================================
    // Divider chain
    // Prescale feeds the PLL reference from the gated input
    clk_divider #(.RST_RATIO(RST_PRESCALE_RATIO), .RST_EN(RST_DIV_ENABLE)) u_prescale (
        .pclk(pclk), .presetn(presetn), .src_edge(ref_edge_g),
        .ratio(ratio[0]), .enable(div_en[0]), .clk_out(pll_reference_clock));
    // Core clock from the selected system source
    clk_divider #(.RST_RATIO(RST_CORE_RATIO), .RST_EN(RST_DIV_ENABLE)) u_core (
        .pclk(pclk), .presetn(presetn), .src_edge(sys_edge),
        .ratio(ratio[1]), .enable(div_en[1]), .clk_out(core_clock));
    // Peripheral bus clock
    clk_divider #(.RST_RATIO(RST_BUS_RATIO), .RST_EN(RST_DIV_ENABLE)) u_bus (
        .pclk(pclk), .presetn(presetn), .src_edge(sys_edge),
        .ratio(ratio[2]), .enable(div_en[2]), .clk_out(peripheral_bus_clock));
    // External memory interface clock
    clk_divider #(.RST_RATIO(RST_MEMORY_RATIO), .RST_EN(RST_DIV_ENABLE)) u_mem (
        .pclk(pclk), .presetn(presetn), .src_edge(sys_edge),
        .ratio(ratio[3]), .enable(div_en[3]), .clk_out(memory_interface_clock));
    // Raw clock straight from the reference, never the PLL [R17]
    clk_divider #(.RST_RATIO(RST_OSC_RATIO), .RST_EN(RST_DIV_ENABLE)) u_osc (
        .pclk(pclk), .presetn(presetn), .src_edge(ref_edge_g),
        .ratio(ratio[4]), .enable(div_en[4]), .clk_out(raw_clock_output));

    // ============================================================
    // Checks
    chk_stable_count: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        $rose(stable_bit) |-> $past(stable_cnt) == 13'(STABLE_EDGES - 1))
        else $error("stable bit rose at wrong count");
    chk_pll_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        wr_done && hit_csr |=> ##1 pll_reset == $past(pwdata[PLL_RESET_POS], 2))
        else $error("PLL reset does not follow its bit");
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        pready && !pslverr && hit_csr |-> prdata[31:7] == 25'h0 && prdata[5:4] == 2'b00
        && prdata[2] == 1'b0) else $error("reserved bits read nonzero");
    chk_bypass_src: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        !act_path |-> sys_edge == ref_edge_g) else $error("bypass not from reference");
    chk_pll_src: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        act_path |-> sys_edge == pll_edge_g) else $error("PLL mode not from PLL");
    chk_mult_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R28]
        act_path |=> $stable(pll_multiplier)) else $error("multiplier changed on PLL path");
    chk_bypass_nostop: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        !act_path |=> !clk_stop) else $error("deep sleep stopped bypassed clocks");
    chk_stop_gates: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
        clk_stop |=> $stable(core_clock) && $stable(raw_clock_output))
        else $error("stopped source still runs");
    chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready |=> pready ##1 !pready) else $error("APB answer timing wrong");

    cov_path_switch: cover property (@(posedge pclk) disable iff (!presetn) $rose(act_path));
    cov_stable: cover property (@(posedge pclk) disable iff (!presetn) $rose(stable_bit));
    cov_deep_stop: cover property (@(posedge pclk) disable iff (!presetn) $rose(clk_stop));
    cov_div_write: cover property (@(posedge pclk) disable iff (!presetn) wr_done && hit_div[1]);
endmodule

// ===== sim/clkgen_ctrl_tb.sv
// Purpose: Self-checking bench for the clock generator controller
// Assumes: Reference period 8 pclk, PLL output period 10 pclk, STABLE_EDGES 8
// Notes: The APB driver queues expected answers, a monitor checks them
`timescale 1ns/100ps
module clkgen_ctrl_tb
    import clkgen_pkg::*;
;
    // ============================================================
    // Signals and tables
    localparam int REF_HALF = 4; // Reference half period in pclk cycles
    localparam int PLL_HALF = 5; // PLL output half period in pclk cycles
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic reference_clock_input = 1'b0;
    logic pll_output_clock = 1'b0;
    logic [5:0] powerdown_select_field = 6'h00;
    logic pll_reset, pll_powerdown, pll_reference_clock;
    logic [4:0] pll_multiplier;
    logic core_clock, peripheral_bus_clock, memory_interface_clock, raw_clock_output;
    int err_count = 0;
    int comparisons = 0;
    int rc = 0; // Reference half-period counter
    int pc = 0; // PLL half-period counter
    logic [31:0] exp_data[$]; // Expected read data, oldest first
    logic exp_err[$]; // Expected error flags, oldest first
    logic [31:0] regs[6] = '{ADDR_PLL_MULTIPLIER, ADDR_PRESCALE_DIVIDER, ADDR_CORE_CLOCK_DIVIDER,
        ADDR_BUS_CLOCK_DIVIDER, ADDR_MEMORY_CLOCK_DIVIDER, ADDR_OSCILLATOR_OUTPUT_DIVIDER};
    logic [31:0] rstv[6] = '{32'h7, 32'h8000, 32'h8000, 32'h8001, 32'h8001, 32'h8007};
    logic [31:0] onesv[6] = '{32'h19, 32'h801F, 32'h801F, 32'h801F, 32'h801F, 32'h801F};
    int perv[4] = '{8, 16, 16, 64}; // Reset periods of core, bus, memory, raw

    // Device under test
    clkgen_ctrl #(.STABLE_EDGES(8)) i_clkgen_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_input(reference_clock_input), .pll_output_clock(pll_output_clock),
        .powerdown_select_field(powerdown_select_field), .pll_reset(pll_reset),
        .pll_powerdown(pll_powerdown), .pll_multiplier(pll_multiplier),
        .pll_reference_clock(pll_reference_clock), .core_clock(core_clock),
        .peripheral_bus_clock(peripheral_bus_clock),
        .memory_interface_clock(memory_interface_clock), .raw_clock_output(raw_clock_output));

    // ============================================================
    // Clocks: pclk, then slow reference and PLL clocks stepped on pclk
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        rc <= (rc == REF_HALF - 1) ? 0 : rc + 1;
        pc <= (pc == PLL_HALF - 1) ? 0 : pc + 1;
        if (rc == REF_HALF - 1) reference_clock_input <= ~reference_clock_input;
        if (pc == PLL_HALF - 1) pll_output_clock <= ~pll_output_clock;
    end

    // ============================================================
    // Reporting
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        give_verdict();
    end

    // Monitor: every answer takes the oldest queued expectation
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_data.size() == 0) begin
                check("unrequested answer", 32'h1, 32'h0);
            end else begin
                check("prdata", prdata, exp_data.pop_front());
                check("pslverr", {31'h0, pslverr}, {31'h0, exp_err.pop_front()});
            end
        end
    end

    // ============================================================
    // APB master: setup, access, hold until pready, then release
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_data.push_back(wr ? 32'h0 : exp);
        exp_err.push_back(err);
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    // ============================================================
    // Clock observation helpers
    function automatic logic pick(input int s);
        case (s)
            0: return core_clock;
            1: return peripheral_bus_clock;
            2: return memory_interface_clock;
            3: return raw_clock_output;
            default: return pll_reference_clock;
        endcase
    endfunction
    // Wait for a level, counting cycles, bounded
    task automatic wait_lvl(input int s, input logic v, inout int c);
        int k;
        for (k = 0; k < 3000 && pick(s) !== v; k++) begin
            @(negedge pclk);
            c++;
        end
        if (k == 3000) begin
            err_count++;
            give_verdict();
        end
    endtask
    // Period in pclk cycles; the second full period is kept, after any update
    task automatic measure(input int s, output int got);
        int c;
        c = 0;
        wait_lvl(s, 1'b0, c);
        wait_lvl(s, 1'b1, c);
        repeat (2) begin
            c = 0;
            wait_lvl(s, 1'b0, c);
            wait_lvl(s, 1'b1, c);
        end
        got = c;
    endtask
    // Number of level changes over a window
    task automatic toggles(input int s, output int t);
        logic last;
        t = 0;
        last = pick(s);
        repeat (300) begin
            @(negedge pclk);
            if (pick(s) !== last) t++;
            last = pick(s);
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        int got, r, i;
        logic [31:0] junk;
        void'($urandom(20));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check("pll_reset", {31'h0, pll_reset}, 32'h1);
        check("pll_multiplier", {27'h0, pll_multiplier}, 32'h7);
        rd(ADDR_PLL_CONTROL_STATUS, 32'h08);
        for (i = 0; i < 6; i++) rd(regs[i], rstv[i]);
        repeat (100) @(posedge pclk);
        rd(ADDR_PLL_CONTROL_STATUS, 32'h48);
        apb(1'b0, 32'h01B7C104, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 32'h01B7C128, 32'hFFFFFFFF, 32'h0, 1'b1);
        // Reserved bits ignored; bit 2 written as zero
        wr(ADDR_PLL_CONTROL_STATUS, 32'hFFFFFFFB);
        rd(ADDR_PLL_CONTROL_STATUS, 32'h4B);
        check("pll_powerdown", {31'h0, pll_powerdown}, 32'h1);
        wr(ADDR_PLL_CONTROL_STATUS, 32'h08);
        for (i = 0; i < 6; i++) begin
            wr(regs[i], 32'hFFFFFFE0 | onesv[i]);
            rd(regs[i], onesv[i]);
            wr(regs[i], rstv[i]);
        end
        // Bypass: every system clock divided straight from the reference
        for (i = 0; i < 4; i++) begin
            measure(i, got);
            check("period", got, perv[i]);
        end
        r = $urandom_range(5, 0);
        junk = $urandom;
        wr(ADDR_MEMORY_CLOCK_DIVIDER, {junk[31:16], 1'b1, junk[14:5], r[4:0]});
        rd(ADDR_MEMORY_CLOCK_DIVIDER, 32'h8000 | r);
        measure(2, got);
        check("memory period", got, 8 * (r + 1));
        // Disabled dividers hold their outputs low
        wr(ADDR_MEMORY_CLOCK_DIVIDER, r);
        wr(ADDR_OSCILLATOR_OUTPUT_DIVIDER, 32'h7);
        repeat (150) @(posedge pclk); // Running periods finish before the enable drops
        for (i = 2; i < 4; i++) begin
            toggles(i, got);
            check("disabled toggles", got, 0);
            check("disabled level", {31'h0, pick(i)}, 32'h0);
        end
        wr(ADDR_MEMORY_CLOCK_DIVIDER, 32'h8001);
        wr(ADDR_OSCILLATOR_OUTPUT_DIVIDER, 32'h8007);
        // A stop code in bypass leaves the clocks running
        powerdown_select_field <= CLOCK_STOP_MODE;
        toggles(0, got);
        check("bypass stop", {31'h0, got > 0}, 32'h1);
        @(posedge pclk);
        powerdown_select_field <= 6'h00;
        // Leave PLL reset, program while bypassed, wait lock, then select PLL
        wr(ADDR_PLL_CONTROL_STATUS, 32'h00);
        wr(ADDR_PLL_MULTIPLIER, 32'h0A);
        wr(ADDR_PRESCALE_DIVIDER, 32'h8001);
        repeat (4) @(posedge pclk);
        check("pll_reset", {31'h0, pll_reset}, 32'h0);
        check("pll_multiplier", {27'h0, pll_multiplier}, 32'h0A);
        repeat (4688) @(posedge pclk);
        wr(ADDR_PLL_CONTROL_STATUS, 32'h01);
        repeat (100) @(posedge pclk); // Source switch waits for a quiet point
        measure(0, got);
        check("pll core period", got, 10);
        measure(4, got);
        check("prescale period", got, 16);
        measure(3, got);
        check("raw period", got, 64);
        wr(ADDR_PLL_MULTIPLIER, 32'h0C);
        rd(ADDR_PLL_MULTIPLIER, 32'h0C);
        repeat (4) @(posedge pclk);
        check("pll_multiplier held", {27'h0, pll_multiplier}, 32'h0A);
        // Slow the bus divider first, then the core divider
        wr(ADDR_BUS_CLOCK_DIVIDER, 32'h8003);
        wr(ADDR_CORE_CLOCK_DIVIDER, 32'h8001);
        measure(0, got);
        check("core period", got, 20);
        measure(1, got);
        check("bus period", got, 40);
        // Stop codes on the PLL path freeze system and raw clocks
        @(posedge pclk);
        powerdown_select_field <= DEEP_SLEEP_MODE;
        repeat (10) @(posedge pclk);
        for (i = 0; i < 4; i++) begin
            toggles(i, got);
            check("stopped toggles", got, 0);
        end
        give_verdict();
    end
endmodule
